/* core/wcm_wake_ctl.v */
// Wake control module: sleep-state decode, power-event interrupt merge, two-pin LED control.
// Assumes slow_clk_32k is a 32 kHz level synchronous to aclk; event inputs are synchronous levels.
`timescale 1ns/1ns
`include "wcm_consts.vh"

module wcm_wake_ctl #(
  parameter          NUM_EVT  = 32,
  parameter          IRQ_W    = 4,
  parameter [12:0]   TICK_DIV = `WCM_TICK_DIV
) (
  input  wire                 aclk,
  input  wire                 aresetn,
  input  wire [31:0]          s_axi_awaddr,
  input  wire                 s_axi_awvalid,
  output reg                  s_axi_awready,
  input  wire [31:0]          s_axi_wdata,
  input  wire [3:0]           s_axi_wstrb,
  input  wire                 s_axi_wvalid,
  output reg                  s_axi_wready,
  output reg  [1:0]           s_axi_bresp,
  output reg                  s_axi_bvalid,
  input  wire                 s_axi_bready,
  input  wire [31:0]          s_axi_araddr,
  input  wire                 s_axi_arvalid,
  output reg                  s_axi_arready,
  output reg  [31:0]          s_axi_rdata,
  output reg  [1:0]           s_axi_rresp,
  output reg                  s_axi_rvalid,
  input  wire                 s_axi_rready,
  input  wire                 sleep_s3_indication_n,
  input  wire                 sleep_s5_indication_n,
  input  wire                 main_supply_power_good,
  input  wire                 main_3v3_supply,
  input  wire                 slow_clk_32k,
  input  wire [NUM_EVT-1:0]   wake_events,
  output reg                  pm_event_interrupt_pin_o,
  output reg                  pm_event_interrupt_pin_oe,
  output reg  [(1<<IRQ_W)-1:0] irq_lines,
  output reg                  green_indicator_pin_o,
  output reg                  green_indicator_pin_oe,
  output reg                  yellow_indicator_pin_o,
  output reg                  yellow_indicator_pin_oe
);

  reg  [7:0]         standard_led_control;
  reg  [7:0]         wake_misc_control_reg;
  reg  [7:0]         advanced_led_control;
  reg  [7:0]         special_led_control;
  reg  [7:0]         led_blink_rates;
  reg  [7:0]         irq_config;
  reg  [NUM_EVT-1:0] event_status;
  reg  [NUM_EVT-1:0] event_enable;
  reg                summary_pm_status_flag;
  reg                summary_pm_enable_bit;
  reg                aw_held;
  reg                w_held;
  reg  [3:0]         aw_idx;
  reg  [31:0]        w_data;
  reg  [3:0]         w_strb;
  reg                slow_d;
  reg  [12:0]        div_cnt;
  reg  [3:0]         tick_cnt;
  reg  [3:0]         std_phase;

  wire [1:0] led_option_select = wake_misc_control_reg[`WCM_MISC_OPT_LSB+1:`WCM_MISC_OPT_LSB];
  // The illegal pair decodes as no state at all; only the special option, with its S1 bit clear, darkens LEDs for it as S5 would
  wire       in_s5 = ~sleep_s3_indication_n & ~sleep_s5_indication_n;
  wire       in_s3 = ~sleep_s3_indication_n & sleep_s5_indication_n;
  wire       in_work = sleep_s3_indication_n & sleep_s5_indication_n;
  wire       sleep_illegal = sleep_s3_indication_n & ~sleep_s5_indication_n;
  wire [1:0] sleep_code = {in_s5, in_s3};

  // Bus handshakes: each address and data beat is latched independently, then committed together
  wire       wr_fire = aw_held & w_held & ~s_axi_bvalid;
  wire [3:0] ar_idx = s_axi_araddr[5:2];
  wire       ar_fire = s_axi_arvalid & s_axi_arready;
  wire       clr_sts = wr_fire & (aw_idx[3:2] == 2'h1) & w_strb[0];
  wire       clr_sum = wr_fire & (aw_idx == `WCM_IDX_SUM_STS) & w_strb[0] & w_data[0];

  wire [NUM_EVT-1:0] sts_clr_mask;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVT; gi = gi + 1) begin : g_evt
      assign sts_clr_mask[gi] = clr_sts & (aw_idx[1:0] == gi / 8) & w_data[gi % 8];
    end
  endgenerate

  // Event bits are sticky; a new event in the clear cycle keeps the bit set
  wire [NUM_EVT-1:0] next_event_status = (event_status & ~sts_clr_mask[NUM_EVT-1:0]) | wake_events;
  wire               pme_cause = |(event_status & event_enable);
  // The flag re-arms while an enabled cause stands, so a clear cannot lose one
  wire               next_summary = (summary_pm_status_flag & ~clr_sum) | pme_cause;
  wire               irq_active = summary_pm_status_flag & summary_pm_enable_bit;

  // Slow clock edge count gives 1/8 s ticks; 1 Hz is 8 ticks, 0.667 Hz is 12
  wire slow_rise = slow_clk_32k & ~slow_d;
  wire tick = slow_rise & (div_cnt == TICK_DIV - 13'd1);
  wire blink_1hz = ~tick_cnt[2];
  wire blink_half = ~tick_cnt[3];
  wire blink_std = (std_phase < `WCM_STD_ON);

  // One time base for every option, so switching options never restarts a blink
  always @(posedge aclk) begin
    if (!aresetn) begin
      slow_d    <= 1'b0;
      div_cnt   <= 13'h0;
      tick_cnt  <= 4'h0;
      std_phase <= 4'h0;
    end else begin
      slow_d <= slow_clk_32k;
      if (slow_rise)
        div_cnt <= (div_cnt == TICK_DIV - 13'd1) ? 13'h0 : div_cnt + 13'd1;
      if (tick) begin
        tick_cnt  <= tick_cnt + 4'd1;
        std_phase <= (std_phase == `WCM_STD_PERIOD - 4'd1) ? 4'h0 : std_phase + 4'd1;
      end
    end
  end

  // Level that a blink field asks for at this instant
  function blink_of;
    input [3:0] code;
    begin
      case (code)
        `WCM_BLK_OFF:     blink_of = 1'b0;
        `WCM_BLK_ON:      blink_of = 1'b1;
        `WCM_BLK_1HZ:     blink_of = blink_1hz;
        `WCM_BLK_HALF_HZ: blink_of = blink_half;
        `WCM_BLK_QTR_HZ:  blink_of = blink_half & blink_1hz;
        `WCM_BLK_STD:     blink_of = blink_std;
        default:          blink_of = 1'b0;
      endcase
    end
  endfunction

  reg       grn_on;
  reg       ylw_on;
  reg       next_grn_o;
  reg       next_grn_oe;
  reg       next_ylw_o;
  reg       next_ylw_oe;
  reg [1:0] adv_mode;
  reg       adv_cfg;
  reg       adv_pol;

  always @* begin
    grn_on      = 1'b0;
    ylw_on      = 1'b0;
    adv_mode    = advanced_led_control[`WCM_ADV_MOD_LSB+1:`WCM_ADV_MOD_LSB];
    adv_cfg     = advanced_led_control[`WCM_ADV_CFG_BIT];
    adv_pol     = advanced_led_control[`WCM_ADV_POL_BIT];
    next_grn_o  = 1'b0;
    next_ylw_o  = 1'b0;
    next_grn_oe = 1'b1;
    next_ylw_oe = 1'b1;
    case (led_option_select)
      `WCM_OPT_STD: begin
        if (!in_s5) begin
          // Only the selected LED may light; the other stays dark
          if (standard_led_control[`WCM_STD_SEL_BIT])
            grn_on = standard_led_control[`WCM_STD_BLINK_BIT] ? blink_std : 1'b1;
          else
            ylw_on = standard_led_control[`WCM_STD_BLINK_BIT] ? blink_std : 1'b1;
        end
      end
      `WCM_OPT_ADV: begin
        grn_on = blink_of(led_blink_rates[`WCM_BLNK_GRN_LSB+3:`WCM_BLNK_GRN_LSB]);
        ylw_on = blink_of(led_blink_rates[`WCM_BLNK_YLW_LSB+3:`WCM_BLNK_YLW_LSB]);
        // Mode overrides follow the fields, so a forced state always wins
        case (adv_mode)
          2'h1: if (!main_3v3_supply) ylw_on = blink_1hz;
          2'h2: if (in_s5) begin
            grn_on = 1'b0;
            ylw_on = 1'b0;
          end
          2'h3: if (!main_3v3_supply) begin
            grn_on = 1'b0;
            ylw_on = 1'b0;
          end
          default: ;
        endcase
      end
      `WCM_OPT_SPC: begin
        if (in_s5) begin
          grn_on = 1'b0;
        end else if (in_s3 | special_led_control[`WCM_SPC_S1_BIT]) begin
          grn_on = blink_1hz;
        end else if (!in_work) begin
          // Illegal sleep pair: keep both dark rather than guess a state
          grn_on = 1'b0;
        end else if (!main_supply_power_good) begin
          ylw_on = blink_1hz;
        end else if (special_led_control[`WCM_SPC_SEL_BIT]) begin
          grn_on = 1'b1;
        end else begin
          ylw_on = 1'b1;
        end
      end
      default: ;
    endcase
    if (led_option_select == `WCM_OPT_ADV) begin
      // Separate LEDs: polarity says which pin level is the on state
      if (adv_cfg) begin
        next_grn_oe = ~(grn_on ^ adv_pol);
        next_ylw_oe = ~(ylw_on ^ adv_pol);
      end else begin
        // Dual-colour LED: polarity 0 floats the lit colour's pin and pulls the other low; polarity 1 swaps them
        next_grn_oe = ~((grn_on & ~adv_pol) | (ylw_on & adv_pol));
        next_ylw_oe = ~((ylw_on & adv_pol) | (grn_on & ~adv_pol)) | (grn_on & ylw_on) | ~(grn_on | ylw_on);
        next_ylw_oe = (grn_on ^ ylw_on) ? ~next_grn_oe : 1'b1;
        if (!(grn_on ^ ylw_on))
          next_grn_oe = 1'b1;
      end
    end else begin
      next_grn_oe = ~grn_on;
      next_ylw_oe = ~ylw_on;
    end
  end

  // Slots of an unselected option read zero, matching the dropped writes
  reg [7:0] rd_byte;
  reg       rd_ok;
  always @* begin
    rd_byte = 8'h00;
    rd_ok   = 1'b1;
    case (ar_idx)
      `WCM_IDX_STD_LED:  rd_byte = (led_option_select == `WCM_OPT_STD) ? standard_led_control : 8'h00;
      `WCM_IDX_MISC_CTL: rd_byte = wake_misc_control_reg;
      `WCM_IDX_ADV_LED:  rd_byte = (led_option_select == `WCM_OPT_ADV) ? advanced_led_control :
                                   (led_option_select == `WCM_OPT_SPC) ? special_led_control : 8'h00;
      `WCM_IDX_BLINK:    rd_byte = (led_option_select == `WCM_OPT_ADV) ? led_blink_rates : 8'h00;
      4'h4, 4'h5, 4'h6, 4'h7: rd_byte = event_status[ar_idx[1:0]*8 +: 8];
      4'h8, 4'h9, 4'ha, 4'hb: rd_byte = event_enable[ar_idx[1:0]*8 +: 8];
      `WCM_IDX_SUM_STS:  rd_byte = {7'h00, summary_pm_status_flag};
      `WCM_IDX_SUM_EN:   rd_byte = {7'h00, summary_pm_enable_bit};
      `WCM_IDX_IRQ_CFG:  rd_byte = irq_config;
      `WCM_IDX_SLEEP:    rd_byte = {5'h00, sleep_illegal, sleep_code};
      default:           rd_ok = 1'b0;
    endcase
    // Refused above the map even where the low bits alias a register
    if (s_axi_araddr[31:6] != 26'h0)
      rd_ok = 1'b0;
  end

  // The sleep decode is read-only; a write to it is refused
  wire wr_ok = (aw_idx != `WCM_IDX_SLEEP);
  wire [7:0] wb = w_data[7:0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'h0;
      s_axi_rdata   <= 32'h0;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_idx  <= 4'h0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      standard_led_control  <= `WCM_RST_STD_LED;
      wake_misc_control_reg <= `WCM_RST_MISC_CTL;
      advanced_led_control  <= `WCM_RST_ADV_LED;
      special_led_control   <= `WCM_RST_SPC_LED;
      led_blink_rates       <= `WCM_RST_BLINK;
      irq_config            <= `WCM_RST_IRQ_CFG;
      event_status          <= {NUM_EVT{1'b0}};
      event_enable          <= {NUM_EVT{1'b0}};
      summary_pm_status_flag <= 1'b0;
      summary_pm_enable_bit  <= 1'b0;
      pm_event_interrupt_pin_o  <= 1'b0;
      pm_event_interrupt_pin_oe <= 1'b0;
      irq_lines <= {(1<<IRQ_W){1'b0}};
      green_indicator_pin_o   <= 1'b0;
      green_indicator_pin_oe  <= 1'b1;
      yellow_indicator_pin_o  <= 1'b0;
      yellow_indicator_pin_oe <= 1'b1;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx  <= s_axi_awaddr[5:2];
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
        if (w_strb[0] & wr_ok) begin
          // A write to a slot of an unselected option is dropped
          case (aw_idx)
            `WCM_IDX_STD_LED: if (led_option_select == `WCM_OPT_STD)
              standard_led_control <= {6'h00, wb[1:0]};
            `WCM_IDX_MISC_CTL: wake_misc_control_reg <= {6'h00, wb[1:0]};
            `WCM_IDX_ADV_LED: begin
              if (led_option_select == `WCM_OPT_ADV)
                advanced_led_control <= {4'h0, wb[3:0]};
              if (led_option_select == `WCM_OPT_SPC)
                special_led_control <= {6'h00, wb[1:0]};
            end
            `WCM_IDX_BLINK: if (led_option_select == `WCM_OPT_ADV)
              led_blink_rates <= wb;
            `WCM_IDX_SUM_EN:  summary_pm_enable_bit <= wb[0];
            `WCM_IDX_IRQ_CFG: irq_config <= wb;
            default: ;
          endcase
        end
        // Enable bytes take every write, whatever the LED option
        if ((aw_idx[3:2] == 2'h2) & w_strb[0])
          event_enable[aw_idx[1:0]*8 +: 8] <= wb;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // Ready pulses one cycle, never while a read answer is pending
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (ar_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_ok ? {24'h0, rd_byte} : 32'h0;
        s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      event_status           <= next_event_status;
      summary_pm_status_flag <= next_summary;
      // Inverted polarity: open-drain floats when asserted, push-pull drives high
      if (irq_config[`WCM_IRQ_OD_BIT]) begin
        pm_event_interrupt_pin_o  <= 1'b0;
        pm_event_interrupt_pin_oe <= irq_active ^ irq_config[`WCM_IRQ_INV_BIT];
      end else begin
        pm_event_interrupt_pin_o  <= ~(irq_active ^ irq_config[`WCM_IRQ_INV_BIT]);
        pm_event_interrupt_pin_oe <= 1'b1;
      end
      irq_lines <= {(1<<IRQ_W){1'b0}};
      irq_lines[irq_config[`WCM_IRQ_NUM_LSB +: IRQ_W]] <= irq_active;
      green_indicator_pin_o   <= next_grn_o;
      green_indicator_pin_oe  <= next_grn_oe;
      yellow_indicator_pin_o  <= next_ylw_o;
      yellow_indicator_pin_oe <= next_ylw_oe;
    end
  end

endmodule // wcm_wake_ctl

/* pkg/wcm_consts.vh */
// Constants for the wake control module: register offsets, field positions, reset values, timing.
// Assumes a 20 MHz bus clock and a 32768 Hz slow clock reaching the block as a synchronous input.
`ifndef WCM_CONSTS_VH
`define WCM_CONSTS_VH

// Register indices (byte address = 4 * index)
`define WCM_IDX_STD_LED      4'h0
`define WCM_IDX_MISC_CTL     4'h1
`define WCM_IDX_ADV_LED      4'h2
`define WCM_IDX_SPC_LED      4'h2
`define WCM_IDX_BLINK        4'h3
`define WCM_IDX_EVT_STS0     4'h4
`define WCM_IDX_EVT_EN0      4'h8
`define WCM_IDX_SUM_STS      4'hc
`define WCM_IDX_SUM_EN       4'hd
`define WCM_IDX_IRQ_CFG      4'he
`define WCM_IDX_SLEEP        4'hf

// LED option codes
`define WCM_OPT_ADV          2'h0
`define WCM_OPT_STD          2'h1
`define WCM_OPT_SPC          2'h2

// Reset values
`define WCM_RST_STD_LED      8'h03
`define WCM_RST_MISC_CTL     8'h02
`define WCM_RST_ADV_LED      8'h00
`define WCM_RST_SPC_LED      8'h00
`define WCM_RST_BLINK        8'h00
`define WCM_RST_IRQ_CFG      8'h00

// Field positions
`define WCM_MISC_OPT_LSB     0
`define WCM_STD_SEL_BIT      0
`define WCM_STD_BLINK_BIT    1
`define WCM_ADV_CFG_BIT      0
`define WCM_ADV_POL_BIT      1
`define WCM_ADV_MOD_LSB      2
`define WCM_SPC_SEL_BIT      0
`define WCM_SPC_S1_BIT       1
`define WCM_BLNK_GRN_LSB     0
`define WCM_BLNK_YLW_LSB     4
`define WCM_IRQ_INV_BIT      0
`define WCM_IRQ_OD_BIT       1
`define WCM_IRQ_NUM_LSB      4

// Blink field codes
`define WCM_BLK_OFF          4'h0
`define WCM_BLK_ON           4'h1
`define WCM_BLK_1HZ          4'h2
`define WCM_BLK_HALF_HZ      4'h3
`define WCM_BLK_QTR_HZ       4'h4
`define WCM_BLK_STD          4'h5

// Slow clock timing: 32768 Hz divided to a 1/8 s tick
`define WCM_SLOW_HZ          32768
`define WCM_TICK_DIV         4096
// 0.667 Hz blink = 12 ticks, on for 5 ticks (41.7 %)
`define WCM_STD_PERIOD       4'd12
`define WCM_STD_ON           4'd5

`endif

/* tb/wcm_acpi_model.sv */
// Chipset power-state model: drives the sleep indications and power good.
// Assumes the bench picks a state code; outputs change just after aclk.
`timescale 1ns/1ns
module wcm_acpi_model (
  input  wire       aclk,
  input  wire [1:0] st,
  input  wire       pg,
  output reg        s3_n,
  output reg        s5_n,
  output reg        pg_o
);
  // Codes: 0 working, 1 S3, 2 S5, 3 the illegal pair
  always @(posedge aclk) begin
    s3_n <= (st == 2'h0) || (st == 2'h3);
    s5_n <= (st == 2'h0) || (st == 2'h1);
    pg_o <= pg;
  end
endmodule // wcm_acpi_model

/* tb/wcm_props_properties.sv */
// Port checker for the wake control block, bound to its top module.
// Assumes one aclk domain; option and buffer type are shadowed from bus writes.
`timescale 1ns/1ns
`include "wcm_consts.vh"
module wcm_props #(
  parameter IRQ_W = 4
) (
  input wire                  aclk,
  input wire                  aresetn,
  input wire [31:0]           s_axi_awaddr,
  input wire                  s_axi_awvalid,
  input wire                  s_axi_awready,
  input wire [31:0]           s_axi_wdata,
  input wire                  s_axi_wvalid,
  input wire                  s_axi_wready,
  input wire [1:0]            s_axi_bresp,
  input wire                  s_axi_bvalid,
  input wire                  s_axi_bready,
  input wire [31:0]           s_axi_araddr,
  input wire                  s_axi_arvalid,
  input wire                  s_axi_arready,
  input wire [31:0]           s_axi_rdata,
  input wire [1:0]            s_axi_rresp,
  input wire                  s_axi_rvalid,
  input wire                  s_axi_rready,
  input wire                  sleep_s3_indication_n,
  input wire                  sleep_s5_indication_n,
  input wire                  pm_event_interrupt_pin_oe,
  input wire [(1<<IRQ_W)-1:0] irq_lines,
  input wire                  green_indicator_pin_o,
  input wire                  green_indicator_pin_oe,
  input wire                  yellow_indicator_pin_o,
  input wire                  yellow_indicator_pin_oe
);
  reg [3:0] aw_i;
  reg [7:0] w_b;
  reg [1:0] opt;
  reg       od;
  // Shadow only committed writes, so a refused write never moves the model
  always @(posedge aclk) begin
    if (!aresetn) begin
      opt <= `WCM_OPT_SPC;
      od  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_i <= s_axi_awaddr[5:2];
      if (s_axi_wvalid && s_axi_wready) w_b <= s_axi_wdata[7:0];
      if (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0) begin
        if (aw_i == `WCM_IDX_MISC_CTL) opt <= w_b[1:0];
        if (aw_i == `WCM_IDX_IRQ_CFG) od <= w_b[`WCM_IRQ_OD_BIT];
      end
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s5_dark;
    (!sleep_s3_indication_n && !sleep_s5_indication_n && (opt == `WCM_OPT_SPC || opt == `WCM_OPT_STD)) [*4];
  endsequence
  sequence pp_held;
    (!od) [*3];
  endsequence
  a_green_open_drain: assert property (green_indicator_pin_o == 1'b0)
    else $error("green pin driven high");
  a_yellow_open_drain: assert property (yellow_indicator_pin_o == 1'b0)
    else $error("yellow pin driven high");
  a_s5_leds_dark: assert property (s5_dark |-> green_indicator_pin_oe && yellow_indicator_pin_oe)
    else $error("LED lit in S5");
  a_push_pull_oe: assert property (pp_held |-> pm_event_interrupt_pin_oe)
    else $error("push-pull interrupt pin not driven");
  a_irq_single_line: assert property ($onehot0(irq_lines))
    else $error("interrupt on several lines");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  a_r_answer: assert property ($rose(s_axi_arvalid) |-> ##[1:8] s_axi_rvalid)
    else $error("read not answered");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[31:6] != 0
    |-> ##[1:4] (s_axi_rvalid && s_axi_rresp == 2'h2)) else $error("unmapped read not refused");
  a_aw_ready_valid: assert property (s_axi_awready |-> s_axi_awvalid)
    else $error("write address taken without request");
endmodule // wcm_props

bind wcm_wake_ctl wcm_props #(.IRQ_W(IRQ_W)) u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .sleep_s3_indication_n(sleep_s3_indication_n),
  .sleep_s5_indication_n(sleep_s5_indication_n), .pm_event_interrupt_pin_oe(pm_event_interrupt_pin_oe),
  .irq_lines(irq_lines), .green_indicator_pin_o(green_indicator_pin_o),
  .green_indicator_pin_oe(green_indicator_pin_oe), .yellow_indicator_pin_o(yellow_indicator_pin_o),
  .yellow_indicator_pin_oe(yellow_indicator_pin_oe));

/* tb/wcm_wake_ctl_tb_top.sv */
// Bench for the wake control block: bus, sleep decode, events, LED options.
// Assumes a 20 MHz aclk and a free-running 32768 Hz slow clock.
`timescale 1ns/1ns
`include "wcm_consts.vh"
module wcm_wake_ctl_tb_top;
  localparam TD = 1;
  reg         aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  reg         arvalid = 1'b0, rready = 1'b0, pg = 1'b1, v33 = 1'b1, slow = 1'b0;
  reg  [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, ev = 32'h0;
  reg  [1:0]  st = 2'h0;
  wire        awready, wready, bvalid, arready, rvalid, s3n, s5n, pgo;
  wire        po, poe, go, goe, yo, yoe;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] irq;
  integer     errors = 0, n_tests = 0, scnt = 0, i;

  initial forever #25 aclk = ~aclk;
  // Edges stay 12 ns off every aclk edge, so the slow level never races the sampling edge
  initial begin
    #12;
    forever #15250 slow = ~slow;
  end
  always @(posedge slow) scnt = scnt + 1;

  wcm_acpi_model u_acpi (.aclk(aclk), .st(st), .pg(pg), .s3_n(s3n), .s5_n(s5n), .pg_o(pgo));
  wcm_wake_ctl #(.TICK_DIV(TD)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sleep_s3_indication_n(s3n), .sleep_s5_indication_n(s5n), .main_supply_power_good(pgo),
    .main_3v3_supply(v33), .slow_clk_32k(slow), .wake_events(ev), .pm_event_interrupt_pin_o(po),
    .pm_event_interrupt_pin_oe(poe), .irq_lines(irq), .green_indicator_pin_o(go),
    .green_indicator_pin_oe(goe), .yellow_indicator_pin_o(yo), .yellow_indicator_pin_oe(yoe));

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d, input [1:0] er);
    integer k;
    @(posedge aclk);
    awaddr <= {24'h0, a};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k = k + 1;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && k < 50);
    chk("bvalid", 1'b1, bvalid);
    chk("bresp", er, bresp);
    bready <= 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] e, input [1:0] er);
    integer k;
    @(posedge aclk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k = k + 1;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && k < 50);
    chk("rvalid", 1'b1, rvalid);
    chk("rresp", er, rresp);
    chk("rdata", e, rdata);
    rready <= 1'b0;
  endtask
  task led(input g, input y);
    repeat (6) @(posedge aclk);
    chk("green_oe", g, goe);
    chk("yellow_oe", y, yoe);
  endtask
  task wo(input g, input v);
    integer k;
    k = 0;
    while ((g ? goe : yoe) !== v && k < 40000) begin
      @(posedge aclk);
      k = k + 1;
    end
  endtask
  // Times are counted in slow-clock edges, the unit the divider works in
  task blink(input g, input integer on, input integer per);
    integer t0, t1;
    wo(g, 1'b1);
    wo(g, 1'b0);
    t0 = scnt;
    wo(g, 1'b1);
    t1 = scnt;
    wo(g, 1'b0);
    chk("on_time", on, t1 - t0);
    chk("period", per, scnt - t0);
  endtask
  task pins(input o, input oe, input [15:0] q);
    repeat (4) @(posedge aclk);
    if (oe) chk("pme_o", o, po);
    chk("pme_oe", oe, poe);
    chk("irq_lines", q, irq);
  endtask
  task pulse(input integer b);
    ev <= 32'h1 << b;
    repeat (2) @(posedge aclk);
    ev <= 32'h0;
    repeat (4) @(posedge aclk);
  endtask

  task t_special;
    rd(8'h04, 8'h02, 2'h0);
    wr(8'h08, 8'h01, 2'h0);
    led(1'b0, 1'b1);
    wr(8'h08, 8'h00, 2'h0);
    led(1'b1, 1'b0);
    wr(8'h08, 8'h02, 2'h0);
    blink(1'b1, 4 * TD, 8 * TD);
    chk("yellow_oe", 1'b1, yoe);
    wr(8'h08, 8'h00, 2'h0);
    st <= 2'h2;
    led(1'b1, 1'b1);
    st <= 2'h0;
    pg <= 1'b0;
    blink(1'b0, 4 * TD, 8 * TD);
    chk("green_oe", 1'b1, goe);
    pg <= 1'b1;
  endtask
  task t_sleep;
    for (i = 0; i < 4; i = i + 1) begin
      st <= i[1:0];
      repeat (4) @(posedge aclk);
      rd(8'h3c, (i == 3) ? 8'h04 : i[7:0], 2'h0);
    end
    st <= 2'h0;
  endtask
  task t_events;
    wr(8'h20, 8'h01, 2'h0);
    wr(8'h34, 8'h01, 2'h0);
    wr(8'h38, 8'h30, 2'h0);
    pulse(1);
    rd(8'h10, 8'h02, 2'h0);
    rd(8'h30, 8'h00, 2'h0);
    pins(1'b1, 1'b1, 16'h0000);
    pulse(0);
    rd(8'h30, 8'h01, 2'h0);
    pins(1'b0, 1'b1, 16'h0008);
    wr(8'h38, 8'h31, 2'h0);
    pins(1'b1, 1'b1, 16'h0008);
    wr(8'h38, 8'h32, 2'h0);
    pins(1'b0, 1'b1, 16'h0008);
    wr(8'h34, 8'h00, 2'h0);
    pins(1'b0, 1'b0, 16'h0000);
    wr(8'h38, 8'h00, 2'h0);
    wr(8'h10, 8'h03, 2'h0);
    wr(8'h30, 8'h01, 2'h0);
    rd(8'h10, 8'h00, 2'h0);
  endtask
  task t_standard;
    wr(8'h04, 8'h01, 2'h0);
    rd(8'h00, 8'h03, 2'h0);
    blink(1'b1, `WCM_STD_ON * TD, `WCM_STD_PERIOD * TD);
    wr(8'h00, 8'h00, 2'h0);
    led(1'b1, 1'b0);
    st <= 2'h2;
    led(1'b1, 1'b1);
    st <= 2'h0;
  endtask
  task t_advanced;
    wr(8'h04, 8'h00, 2'h0);
    rd(8'h00, 8'h00, 2'h0);
    wr(8'h0c, 8'h01, 2'h0);
    wr(8'h08, 8'h01, 2'h0);
    led(1'b0, 1'b1);
    wr(8'h08, 8'h03, 2'h0);
    led(1'b1, 1'b0);
    wr(8'h0c, 8'h10, 2'h0);
    led(1'b0, 1'b1);
    wr(8'h08, 8'h00, 2'h0);
    led(1'b1, 1'b0);
    wr(8'h08, 8'h0d, 2'h0);
    v33 <= 1'b0;
    led(1'b1, 1'b1);
    v33 <= 1'b1;
    wr(8'h08, 8'h09, 2'h0);
    st <= 2'h2;
    led(1'b1, 1'b1);
    st <= 2'h0;
    led(1'b1, 1'b0);
    wr(8'h08, 8'h05, 2'h0);
    v33 <= 1'b0;
    blink(1'b0, 4 * TD, 8 * TD);
    chk("green_oe", 1'b1, goe);
    v33 <= 1'b1;
  endtask

  task summarize;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_special;
    t_sleep;
    t_events;
    t_standard;
    t_advanced;
    rd(8'h40, 8'h00, 2'h2);
    wr(8'h3c, 8'h00, 2'h2);
    summarize;
  end
  initial begin
    #(90000 * 50);
    errors = errors + 1;
    summarize;
  end
endmodule // wcm_wake_ctl_tb_top
